// >>> pkg/fptl_pkg.sv
// Constants, register map and field layout of the feeder protection trip logic.
package fptl_pkg;
    // Clock and time base.
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int ALARM_DELAY_MS = 40;

    // Widths.
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int TIME_W  = 16;
    localparam int MULT_W  = 4;
    localparam int TICK_W  = 8;
    localparam int MSCNT_W = 17;
    localparam int NSTAGE  = 4;
    localparam int NIRQ    = 5;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BLOCK_MAP  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TICK_MS    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OC_LOW_T   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OC_HIGH_T  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EF_LOW_T   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EF_HIGH_T  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATE      = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h24;

    // Control register fields.
    localparam int CTRL_IDMT_BIT   = 0;
    localparam int CTRL_SECOND_BIT = 1;
    localparam int CTRL_COMMON_BIT = 2;
    localparam int CTRL_GATE_BIT   = 3;
    localparam int CTRL_W          = 4;

    // Block map fields: stage order is oc low, oc high, ef low, ef high.
    localparam int BMAP_A_LSB = 0;
    localparam int BMAP_B_LSB = 4;
    localparam int BMAP_W     = 8;

    // State register fields.
    localparam int ST_START_LSB = 0;
    localparam int ST_TRIP_LSB  = 4;
    localparam int ST_RELAY_LSB = 8;
    localparam int NRELAY       = 6;

    // Stage indices and the internal-fault interrupt bit.
    localparam int STG_OCL = 0;
    localparam int STG_OCH = 1;
    localparam int STG_EFL = 2;
    localparam int STG_EFH = 3;
    localparam int IRQ_IRF = 4;

    // Reset values and the unit timer step.
    localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
    localparam logic [BMAP_W-1:0] BMAP_RST  = 8'h00;
    localparam logic [TICK_W-1:0] TICK_RST  = 8'h01;
    localparam logic [TIME_W-1:0] TIME_RST  = 16'h0064;
    localparam logic [NIRQ-1:0]   IRQ_RST   = 5'h00;
    localparam logic [MULT_W-1:0] STEP_ONE  = 4'h1;
endpackage

// >>> src/fptl_stage_timer.sv
// Start detection and operate timer shared by protection stages and the alarm delay.
`timescale 1ns/1ps
`default_nettype none
module fptl_stage_timer
    import fptl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              tick,
    input  wire logic              cond,
    input  wire logic [MULT_W-1:0] step,
    input  wire logic [TIME_W-1:0] limit,
    output logic                   started,
    output logic                   tripped
);
    logic [TIME_W:0] acc_r;
    logic [TIME_W:0] acc_nxt;
    logic [TIME_W:0] accSum;
    logic            expired;
    logic [MULT_W-1:0] stepEff;

    // A zero step would freeze the timer, so it counts at least one unit.
    assign stepEff = (step == '0) ? STEP_ONE : step;
    assign accSum  = acc_r + {{(TIME_W+1-MULT_W){1'b0}}, stepEff};
    assign expired = acc_r >= {1'b0, limit};

    always_comb
    begin
        acc_nxt = acc_r;
        if (!cond)
            acc_nxt = '0;                                        // RULE16
        else if (tick && !expired)
            acc_nxt = accSum;                                    // RULE2
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_r   <= '0;
            started <= 1'b0;
            tripped <= 1'b0;
        end
        else
        begin
            acc_r   <= acc_nxt;
            started <= cond;                                     // RULE2
            tripped <= cond && expired;                          // RULE2
        end
    end
endmodule
`default_nettype wire

// >>> src/fptl_trip_logic.sv
// Feeder protection stages, blocking, output relay routing and register file.
//
// Functional notes
// RULE1 - Two overcurrent stages; low one definite or inverse time, high one definite only.
// RULE2 - A met start condition raises start and runs the timer; expiry raises trip.
// RULE3 - High overcurrent stage starts above its own level, times and trips independently.
// RULE4 - Earth-fault low stage starts only with residual voltage and current measure exceeded.
// RULE5 - Earth-fault stages trip when their own operate time elapses after starting.
// RULE6 - Shared self-supervision signal drives a dedicated internal-fault relay.
// RULE7 - Relay A trips on any of the four protection stage trips.
// RULE8 - Relay B is overcurrent final-trip alarm or a second trip output.
// RULE9 - Relay C is earth-fault final-trip alarm or common alarm of all stages.
// RULE10 - Relay D follows both overcurrent starts; relay E the earth-fault low start.
// RULE11 - Relays B and C operate 40 ms after their source, on top of stage delay.
// RULE12 - Second-trip selection bypasses the fixed delay for relay B.
// RULE13 - A common output gate must be high for any relay to operate.
// RULE14 - Two blocking inputs suppress tripping of the stages assigned to each.
// RULE15 - An external input picks sine or cosine current component for earth fault.
// RULE16 - A start that clears before expiry drops start and resets the timer untripped.
// RULE17 - Timers count a tick derived from the clock with configurable millisecond step.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fptl_trip_logic
    import fptl_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic      [DATA_W-1:0] regRdData,
    input  wire logic              ocLowOver,
    input  wire logic [MULT_W-1:0] ocLowMultiple,
    input  wire logic              ocHighOver,
    input  wire logic              efVoltOver,
    input  wire logic              efLowSinOver,
    input  wire logic              efLowCosOver,
    input  wire logic              efHighSinOver,
    input  wire logic              efHighCosOver,
    input  wire logic              efComponentSelect,
    input  wire logic              tripBlockA,
    input  wire logic              tripBlockB,
    input  wire logic              reclosePending,
    input  wire logic              faultProtection,
    input  wire logic              faultControl,
    output logic                   relayA,
    output logic                   relayB,
    output logic                   relayC,
    output logic                   relayD,
    output logic                   relayE,
    output logic                   relayF,
    output logic                   irq
);
    // Register file.
    logic [CTRL_W-1:0] ctrl_r;
    logic [BMAP_W-1:0] blockMap_r;
    logic [TICK_W-1:0] tickMs_r;
    logic [TIME_W-1:0] ocLowTime_r;
    logic [TIME_W-1:0] ocHighTime_r;
    logic [TIME_W-1:0] efLowTime_r;
    logic [TIME_W-1:0] efHighTime_r;
    logic [NIRQ-1:0]   irqStatus_r;
    logic [NIRQ-1:0]   irqStatus_nxt;
    logic [NIRQ-1:0]   irqMask_r;
    logic [DATA_W-1:0] rdData_nxt;

    // Time base.
    logic [MSCNT_W-1:0] msCnt_r;
    logic [TICK_W-1:0]  tickCnt_r;
    logic               msPulse_r;
    logic               tickPulse_r;
    logic               msWrap;
    logic               tickWrap;
    logic [TICK_W-1:0]  tickLast;

    // Stage signals.
    logic [NSTAGE-1:0] stageCond;
    logic [NSTAGE-1:0] stageStart;
    logic [NSTAGE-1:0] stageExpired;
    logic [NSTAGE-1:0] stageTrip;
    logic [NSTAGE-1:0] stageTripPrev_r;
    logic [NSTAGE-1:0] blockedStages;
    logic [MULT_W-1:0] ocLowStep;
    logic              efLowMeasure;
    logic              efHighMeasure;
    logic              ocLowStageStart;
    logic              ocHighStageStart;
    logic              efLowStageStart;
    logic              ocLowStageTrip;
    logic              ocHighStageTrip;
    logic              efLowStageTrip;
    logic              efHighStageTrip;

    // Relay routing.
    logic anyTrip;
    logic ocFinalTrip;
    logic efFinalTrip;
    logic relayBSource;
    logic relayCSource;
    logic relayBDelayed;
    logic relayCDelayed;
    logic relayBDrive;
    logic internalFaultFlag;
    logic internalFaultPrev_r;
    logic outputGate;
    logic secondTripSelectSwitch;
    logic commonAlarmSelect;
    logic idmtSelect;
    logic [NIRQ-1:0] irqEvents;
    logic [NRELAY-1:0] relayVec;

    // Address decode.
    logic selCtrl;
    logic selBlockMap;
    logic selTickMs;
    logic selOcLowT;
    logic selOcHighT;
    logic selEfLowT;
    logic selEfHighT;
    logic selState;
    logic selIrqStatus;
    logic selIrqMask;

    // Zero-extends a narrow field into a bus word.
    function automatic logic [DATA_W-1:0] ext16(input logic [TIME_W-1:0] v);
        ext16 = {{(DATA_W-TIME_W){1'b0}}, v};
    endfunction

    // Final trip: the stage tripped and no reclosing shot will follow.
    function automatic logic final_trip(input logic trip, input logic pending);
        final_trip = trip && !pending;
    endfunction

    assign selCtrl      = regAddr == OFS_CTRL;
    assign selBlockMap  = regAddr == OFS_BLOCK_MAP;
    assign selTickMs    = regAddr == OFS_TICK_MS;
    assign selOcLowT    = regAddr == OFS_OC_LOW_T;
    assign selOcHighT   = regAddr == OFS_OC_HIGH_T;
    assign selEfLowT    = regAddr == OFS_EF_LOW_T;
    assign selEfHighT   = regAddr == OFS_EF_HIGH_T;
    assign selState     = regAddr == OFS_STATE;
    assign selIrqStatus = regAddr == OFS_IRQ_STATUS;
    assign selIrqMask   = regAddr == OFS_IRQ_MASK;

    assign idmtSelect             = ctrl_r[CTRL_IDMT_BIT];
    assign secondTripSelectSwitch = ctrl_r[CTRL_SECOND_BIT];
    assign commonAlarmSelect      = ctrl_r[CTRL_COMMON_BIT];
    assign outputGate             = ctrl_r[CTRL_GATE_BIT];

    // Millisecond base and the configurable operate-timer tick.
    assign msWrap   = msCnt_r == MSCNT_W'(CYCLES_PER_MS - 1);
    assign tickLast = (tickMs_r == '0) ? '0 : tickMs_r - TICK_RST;
    assign tickWrap = tickCnt_r >= tickLast;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            msCnt_r     <= '0;
            tickCnt_r   <= '0;
            msPulse_r   <= 1'b0;
            tickPulse_r <= 1'b0;
        end
        else
        begin
            msCnt_r     <= msWrap ? '0 : msCnt_r + 1'b1;
            msPulse_r   <= msWrap;
            tickPulse_r <= msPulse_r && tickWrap;                // RULE17
            if (msPulse_r)
                tickCnt_r <= tickWrap ? '0 : tickCnt_r + 1'b1;   // RULE17
        end
    end

    // Start conditions of the four stages.
    assign efLowMeasure  = efComponentSelect ? efLowSinOver : efLowCosOver;    // RULE15
    assign efHighMeasure = efComponentSelect ? efHighSinOver : efHighCosOver;  // RULE15
    assign ocLowStep     = idmtSelect ? ocLowMultiple : STEP_ONE;              // RULE1
    assign stageCond[STG_OCL] = ocLowOver;
    assign stageCond[STG_OCH] = ocHighOver;                                    // RULE3
    assign stageCond[STG_EFL] = efVoltOver && efLowMeasure;                    // RULE4
    assign stageCond[STG_EFH] = efVoltOver && efHighMeasure;                   // RULE5

    fptl_stage_timer u_ocLow
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (tickPulse_r),
        .cond    (stageCond[STG_OCL]),
        .step    (ocLowStep),
        .limit   (ocLowTime_r),
        .started (stageStart[STG_OCL]),
        .tripped (stageExpired[STG_OCL])
    );

    fptl_stage_timer u_ocHigh
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (tickPulse_r),
        .cond    (stageCond[STG_OCH]),
        .step    (STEP_ONE),
        .limit   (ocHighTime_r),
        .started (stageStart[STG_OCH]),
        .tripped (stageExpired[STG_OCH])
    );

    fptl_stage_timer u_efLow
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (tickPulse_r),
        .cond    (stageCond[STG_EFL]),
        .step    (STEP_ONE),
        .limit   (efLowTime_r),
        .started (stageStart[STG_EFL]),
        .tripped (stageExpired[STG_EFL])
    );

    fptl_stage_timer u_efHigh
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (tickPulse_r),
        .cond    (stageCond[STG_EFH]),
        .step    (STEP_ONE),
        .limit   (efHighTime_r),
        .started (stageStart[STG_EFH]),
        .tripped (stageExpired[STG_EFH])
    );

    // Blocking suppresses the trip only; the start and the timer keep running.
    assign blockedStages = ({NSTAGE{tripBlockA}} & blockMap_r[BMAP_A_LSB +: NSTAGE])
                         | ({NSTAGE{tripBlockB}} & blockMap_r[BMAP_B_LSB +: NSTAGE]); // RULE14
    assign stageTrip = stageExpired & ~blockedStages;                                  // RULE14

    assign ocLowStageStart  = stageStart[STG_OCL];
    assign ocHighStageStart = stageStart[STG_OCH];
    assign efLowStageStart  = stageStart[STG_EFL];
    assign ocLowStageTrip   = stageTrip[STG_OCL];
    assign ocHighStageTrip  = stageTrip[STG_OCH];
    assign efLowStageTrip   = stageTrip[STG_EFL];
    assign efHighStageTrip  = stageTrip[STG_EFH];

    // Relay sources.
    assign anyTrip     = |stageTrip;                                            // RULE7
    assign ocFinalTrip = final_trip(ocLowStageTrip || ocHighStageTrip, reclosePending);
    assign efFinalTrip = final_trip(efLowStageTrip || efHighStageTrip, reclosePending);
    assign relayBSource = secondTripSelectSwitch ? anyTrip : ocFinalTrip;       // RULE8
    assign relayCSource = commonAlarmSelect ? anyTrip : efFinalTrip;            // RULE9
    assign internalFaultFlag = faultProtection || faultControl;                 // RULE6

    // Fixed alarm delay counted on the millisecond base.
    fptl_stage_timer u_delayB
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (msPulse_r),
        .cond    (relayBSource),
        .step    (STEP_ONE),
        .limit   (TIME_W'(ALARM_DELAY_MS)),
        .started (),
        .tripped (relayBDelayed)
    );                                                                          // RULE11

    fptl_stage_timer u_delayC
    (
        .clk     (clk),
        .rst     (rst),
        .tick    (msPulse_r),
        .cond    (relayCSource),
        .step    (STEP_ONE),
        .limit   (TIME_W'(ALARM_DELAY_MS)),
        .started (),
        .tripped (relayCDelayed)
    );                                                                          // RULE11

    assign relayBDrive = secondTripSelectSwitch ? relayBSource : relayBDelayed; // RULE12

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            relayA <= 1'b0;
            relayB <= 1'b0;
            relayC <= 1'b0;
            relayD <= 1'b0;
            relayE <= 1'b0;
            relayF <= 1'b0;
        end
        else
        begin
            relayA <= outputGate && anyTrip;                                    // RULE13
            relayB <= outputGate && relayBDrive;                                // RULE13
            relayC <= outputGate && relayCDelayed;                              // RULE13
            relayD <= outputGate && (ocLowStageStart || ocHighStageStart);      // RULE10
            relayE <= outputGate && efLowStageStart;                            // RULE10
            relayF <= outputGate && internalFaultFlag;                          // RULE6
        end
    end

    // Interrupt events: a new trip of any stage, or a new internal fault.
    assign irqEvents[NSTAGE-1:0] = stageTrip & ~stageTripPrev_r;
    assign irqEvents[IRQ_IRF]    = internalFaultFlag && !internalFaultPrev_r;
    // A new event in the cycle of a clear keeps its bit set.
    assign irqStatus_nxt = (irqStatus_r & ~((regWrEn && selIrqStatus) ?
                            regWrData[NIRQ-1:0] : IRQ_RST)) | irqEvents;

    // Register writes.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r              <= CTRL_RST;
            blockMap_r          <= BMAP_RST;
            tickMs_r            <= TICK_RST;
            ocLowTime_r         <= TIME_RST;
            ocHighTime_r        <= TIME_RST;
            efLowTime_r         <= TIME_RST;
            efHighTime_r        <= TIME_RST;
            irqStatus_r         <= IRQ_RST;
            irqMask_r           <= IRQ_RST;
            stageTripPrev_r     <= '0;
            internalFaultPrev_r <= 1'b0;
            irq                 <= 1'b0;
        end
        else
        begin
            if (regWrEn && selCtrl)
                ctrl_r <= regWrData[CTRL_W-1:0];
            if (regWrEn && selBlockMap)
                blockMap_r <= regWrData[BMAP_W-1:0];
            if (regWrEn && selTickMs)
                tickMs_r <= regWrData[TICK_W-1:0];
            if (regWrEn && selOcLowT)
                ocLowTime_r <= regWrData[TIME_W-1:0];
            if (regWrEn && selOcHighT)
                ocHighTime_r <= regWrData[TIME_W-1:0];
            if (regWrEn && selEfLowT)
                efLowTime_r <= regWrData[TIME_W-1:0];
            if (regWrEn && selEfHighT)
                efHighTime_r <= regWrData[TIME_W-1:0];
            if (regWrEn && selIrqMask)
                irqMask_r <= regWrData[NIRQ-1:0];
            irqStatus_r         <= irqStatus_nxt;
            stageTripPrev_r     <= stageTrip;
            internalFaultPrev_r <= internalFaultFlag;
            irq                 <= |(irqStatus_nxt & irqMask_r);
        end
    end

    // Register reads: data stand for one cycle only; unmapped words read zero.
    assign relayVec = {relayF, relayE, relayD, relayC, relayB, relayA};

    always_comb
    begin
        rdData_nxt = '0;
        if (regRdEn)
        begin
            if (selCtrl)
                rdData_nxt[CTRL_W-1:0] = ctrl_r;
            else if (selBlockMap)
                rdData_nxt[BMAP_W-1:0] = blockMap_r;
            else if (selTickMs)
                rdData_nxt[TICK_W-1:0] = tickMs_r;
            else if (selOcLowT)
                rdData_nxt = ext16(ocLowTime_r);
            else if (selOcHighT)
                rdData_nxt = ext16(ocHighTime_r);
            else if (selEfLowT)
                rdData_nxt = ext16(efLowTime_r);
            else if (selEfHighT)
                rdData_nxt = ext16(efHighTime_r);
            else if (selState)
            begin
                rdData_nxt[ST_START_LSB +: NSTAGE] = stageStart;
                rdData_nxt[ST_TRIP_LSB +: NSTAGE]  = stageTrip;
                rdData_nxt[ST_RELAY_LSB +: NRELAY] = relayVec;
            end
            else if (selIrqStatus)
                rdData_nxt[NIRQ-1:0] = irqStatus_r;
            else if (selIrqMask)
                rdData_nxt[NIRQ-1:0] = irqMask_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            regRdData <= '0;
        else
            regRdData <= rdData_nxt;
    end
endmodule
`default_nettype wire

// >>> testbench/fptl_station_model.sv
// Breaker trip circuit and station alarm panel behind the relays.
`timescale 1ns/1ps
`default_nettype none
module fptl_station_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic relayA,
    input  wire logic relayB,
    input  wire logic relayC,
    output logic      breakerOpen,
    output logic      alarmSeen
);
    // Breaker latches open on a trip contact until reset.
    always_ff @(posedge clk)
    begin
        breakerOpen <= !rst && (breakerOpen || relayA);
        alarmSeen   <= !rst && (alarmSeen || relayB || relayC);
    end
endmodule
`default_nettype wire

// >>> testbench/fptl_trip_logic_props.sv
// Port-level checker of the trip logic.
`timescale 1ns/1ps
`default_nettype none
module fptl_trip_props
    import fptl_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ocLowOver,
    input wire logic ocHighOver,
    input wire logic efVoltOver,
    input wire logic efLowSinOver,
    input wire logic efLowCosOver,
    input wire logic efHighSinOver,
    input wire logic efHighCosOver,
    input wire logic efComponentSelect,
    input wire logic faultProtection,
    input wire logic faultControl,
    input wire logic relayA,
    input wire logic relayB,
    input wire logic relayC,
    input wire logic relayD,
    input wire logic relayE,
    input wire logic relayF
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic anyCond;
    logic [15:0] runCnt_r;
    assign anyCond = ocLowOver | ocHighOver | efLowSinOver | efLowCosOver
                   | efHighSinOver | efHighCosOver;
    // Run length of any start condition.
    always_ff @(posedge clk)
    begin
        if (rst || !anyCond)
            runCnt_r <= 16'h0000;
        else if (runCnt_r != 16'hFFFF)
            runCnt_r <= runCnt_r + 16'h0001;
    end
    sequence s_quiet; !anyCond; endsequence
    sequence s_relaysOff; ##2 (!relayA && !relayB && !relayD && !relayE); endsequence
    property p_relayA_src; relayA |-> $past(anyCond, 2); endproperty
    property p_relayB_src; relayB |-> $past(anyCond, 2) || $past(anyCond, 3); endproperty
    property p_relayD_src; relayD |-> $past(ocLowOver, 2) || $past(ocHighOver, 2); endproperty
    property p_relayE_volt; relayE |-> $past(efVoltOver, 2); endproperty
    property p_relayE_comp;
        relayE |-> ($past(efComponentSelect, 2) ? $past(efLowSinOver, 2)
                                                : $past(efLowCosOver, 2));
    endproperty
    property p_relayF_src; relayF |-> $past(faultProtection) || $past(faultControl); endproperty
    property p_relayC_delay; $rose(relayC) |-> $past(runCnt_r, 3) >= 39*CYCLES_PER_MS; endproperty
    property p_dropClears; s_quiet ##1 s_quiet |-> s_relaysOff; endproperty
    a_relayA_src: assert property (p_relayA_src) else $error("relayA without a stage");
    a_relayB_src: assert property (p_relayB_src) else $error("relayB without a stage");
    a_relayD_src: assert property (p_relayD_src) else $error("relayD without oc start");
    a_relayE_volt: assert property (p_relayE_volt) else $error("relayE without voltage");
    a_relayE_comp: assert property (p_relayE_comp) else $error("relayE wrong component");
    a_relayF_src: assert property (p_relayF_src) else $error("relayF without a fault");
    a_relayC_delay: assert property (p_relayC_delay) else $error("relayC too early");
    a_dropClears: assert property (p_dropClears) else $error("relay held after drop");
endmodule
bind fptl_trip_logic fptl_trip_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) fptl_trip_props_inst (.*);
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking testbench of the feeder protection trip logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fptl_pkg::*;
    localparam int CPM = 5;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWrData = 32'h0;
    logic [DATA_W-1:0] regRdData;
    logic [MULT_W-1:0] ocLowMultiple = 4'h1;
    logic              regWrEn, regRdEn, ocLowOver, ocHighOver, efVoltOver, efLowSinOver;
    logic              efLowCosOver, efHighSinOver, efHighCosOver, efComponentSelect;
    logic              tripBlockA, tripBlockB, reclosePending, faultProtection, faultControl;
    logic              relayA, relayB, relayC, relayD, relayE, relayF, irq;
    logic              breakerOpen, alarmSeen;
    wire logic [5:0]   relays = {relayF, relayE, relayD, relayC, relayB, relayA};
    int                bad_count = 0;
    int                compares = 0;
    int                cycles = 0;
    int                n;
    fptl_trip_logic #(.CYCLES_PER_MS(CPM)) fptl_trip_logic_inst (.*);
    fptl_station_model fptl_station_model_inst (.*);
    always #12.5 clk = ~clk;
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            $display("FAIL %0t timed out", $time);
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkIn(input int v, input int lo, input int hi);
        compares++;
        if (v < lo || v > hi)
        begin
            bad_count++;
            $display("FAIL %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    task automatic waitRel(input int i, output int k);
        k = 0;
        while (relays[i] !== 1'b1 && k < 400)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic quiet;
        @(posedge clk);
        {ocLowOver, ocHighOver, efVoltOver, efLowSinOver} <= 4'h0;
        {efLowCosOver, efHighSinOver, efHighCosOver} <= 3'h0;
        repeat (4) @(negedge clk);
        chk(relays, 32'h0);
    endtask
    task automatic t_gate;
        @(posedge clk) ocHighOver <= 1'b1;
        repeat (40) @(negedge clk);
        chk({relays, breakerOpen}, 32'h0);
        rdChk(OFS_STATE, 32'h22);
        wr(OFS_CTRL, 32'hE);
        waitRel(0, n);
        chkIn(n, 1, 3);
        chk({relayB, relayD}, 32'h3);
        waitRel(2, n);
        chkIn(n, 190, 210);
        quiet();
        chk({breakerOpen, alarmSeen}, 32'h3);
    endtask
    task automatic t_oc;
        wr(OFS_CTRL, 32'h8);
        @(posedge clk) ocHighOver <= 1'b1;
        waitRel(3, n);
        chkIn(n, 3, 3);
        waitRel(0, n);
        chkIn(n, 12, 26);
        waitRel(1, n);
        chkIn(n, 190, 210);
        quiet();
        wr(OFS_CTRL, 32'h9);
        @(posedge clk) ocLowMultiple <= 4'h4;
        ocLowOver <= 1'b1;
        waitRel(0, n);
        chkIn(n, 6, 18);
        quiet();
    endtask
    task automatic t_block;
        wr(OFS_BLOCK_MAP, 32'h2);
        @(posedge clk) tripBlockA <= 1'b1;
        ocHighOver <= 1'b1;
        repeat (40) @(negedge clk);
        chk({relayA, relayD}, 32'h1);
        @(posedge clk) tripBlockA <= 1'b0;
        waitRel(0, n);
        chkIn(n, 1, 3);
        quiet();
    endtask
    task automatic t_ef;
        @(posedge clk) {efVoltOver, efLowSinOver, efComponentSelect} <= 3'h6;
        repeat (20) @(negedge clk);
        chk(relays, 32'h0);
        @(posedge clk) efComponentSelect <= 1'b1;
        waitRel(4, n);
        chkIn(n, 3, 3);
        waitRel(0, n);
        chkIn(n, 1, 20);
        quiet();
        @(posedge clk) {efVoltOver, efHighCosOver, efComponentSelect} <= 3'h6;
        waitRel(0, n);
        chkIn(n, 2, 20);
        chk(relayE, 32'h0);
        quiet();
    endtask
    task automatic t_fault;
        wr(OFS_IRQ_MASK, 32'h10);
        @(posedge clk) faultControl <= 1'b1;
        waitRel(5, n);
        chkIn(n, 1, 2);
        repeat (3) @(negedge clk);
        chk(irq, 32'h1);
        @(posedge clk) faultControl <= 1'b0;
        wr(OFS_IRQ_STATUS, 32'h10);
        repeat (3) @(negedge clk);
        chk({irq, relayF}, 32'h0);
    endtask
    initial
    begin
        {regWrEn, regRdEn, ocLowOver, ocHighOver, efVoltOver, efLowSinOver} = 6'h00;
        {efLowCosOver, efHighSinOver, efHighCosOver, efComponentSelect} = 4'h0;
        {tripBlockA, tripBlockB, reclosePending, faultProtection, faultControl} = 5'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdChk(OFS_TICK_MS, 32'h1);
        rdChk(8'h30, 32'h0);
        for (int i = 0; i < 4; i++)
            rdChk(OFS_OC_LOW_T + 8'(4 * i), 32'h64);
        wr(OFS_OC_HIGH_T, 32'h4);
        wr(OFS_OC_LOW_T, 32'h8);
        wr(OFS_EF_LOW_T, 32'h2);
        wr(OFS_EF_HIGH_T, 32'h2);
        t_gate();
        t_oc();
        t_block();
        t_ef();
        t_fault();
        conclude();
    end
endmodule
`default_nettype wire
